// ### logic/pss_cfg.svh
`ifndef PSS_CFG_SVH
`define PSS_CFG_SVH

// ============================================================
// widths and layout of the counter words
`define PSS_PORTS 3
`define PSS_PER_PORT 32
`define PSS_PORT_ENTRIES 96
`define PSS_CNT_W 30
`define PSS_DROP_W 16
`define PSS_DROP_ENTRIES 6
`define PSS_LEN_W 11
`define PSS_OVF_BIT 31
`define PSS_VALID_BIT 30
`define PSS_PORT_LAST_INDEX 8'h5f
`define PSS_DROP_LAST_INDEX 8'h05
`define PSS_DROP_RX_FIRST 3

// ============================================================
// table select values written before the index byte
`define PSS_SEL_PORT 8'h1c
`define PSS_SEL_DROP 8'h1d

// ============================================================
// per-port counter offsets
`define PSS_OFF_RX_LOW_PRIO_OCTETS 5'h00
`define PSS_OFF_RX_HIGH_PRIO_OCTETS 5'h01
`define PSS_OFF_RX_SHORT_FRAMES 5'h02
`define PSS_OFF_RX_BROKEN_FRAGMENTS 5'h03
`define PSS_OFF_RX_LONG_FRAMES 5'h04
`define PSS_OFF_RX_LONG_ERRORED_FRAMES 5'h05
`define PSS_OFF_RX_BAD_SYMBOL_FRAMES 5'h06
`define PSS_OFF_RX_BAD_CHECK_FRAMES 5'h07
`define PSS_OFF_RX_MISALIGNED_FRAMES 5'h08
`define PSS_OFF_RX_MAC_CONTROL_FRAMES 5'h09
`define PSS_OFF_RX_FLOW_STOP_FRAMES 5'h0a
`define PSS_OFF_RX_ALL_STATIONS_FRAMES 5'h0b
`define PSS_OFF_RX_GROUP_FRAMES 5'h0c
`define PSS_OFF_RX_SINGLE_DEST_FRAMES 5'h0d
`define PSS_OFF_RX_LEN_MIN_BIN 5'h0e
`define PSS_OFF_RX_LEN_BIN_2 5'h0f
`define PSS_OFF_RX_LEN_BIN_3 5'h10
`define PSS_OFF_RX_LEN_BIN_4 5'h11
`define PSS_OFF_RX_LEN_BIN_5 5'h12
`define PSS_OFF_RX_LEN_BIN_6 5'h13
`define PSS_OFF_TX_LOW_PRIO_OCTETS 5'h14
`define PSS_OFF_TX_HIGH_PRIO_OCTETS 5'h15
`define PSS_OFF_TX_LATE_HIT_COUNT 5'h16
`define PSS_OFF_TX_FLOW_STOP_FRAMES 5'h17
`define PSS_OFF_TX_ALL_STATIONS_FRAMES 5'h18
`define PSS_OFF_TX_GROUP_FRAMES 5'h19
`define PSS_OFF_TX_SINGLE_DEST_FRAMES 5'h1a
`define PSS_OFF_TX_POSTPONED_FRAMES 5'h1b
`define PSS_OFF_TX_ALL_HITS 5'h1c
`define PSS_OFF_TX_ABANDONED_FRAMES 5'h1d
`define PSS_OFF_TX_ONE_HIT_FRAMES 5'h1e
`define PSS_OFF_TX_MULTI_HIT_FRAMES 5'h1f

// ============================================================
// frame length boundaries in bytes
`define PSS_LEN_MIN 11'h040
`define PSS_LEN_BIN2_TOP 11'h07f
`define PSS_LEN_BIN3_TOP 11'h0ff
`define PSS_LEN_BIN4_TOP 11'h1ff
`define PSS_LEN_BIN5_TOP 11'h3ff
`define PSS_LEN_LIMIT_STD 11'h5f2
`define PSS_LEN_LIMIT_EXT 11'h600

`endif

// ### logic/pss_frame_classifier.sv
`timescale 1ns/1ns
`include "pss_cfg.svh"

module pss_frame_classifier (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_max_frame_ext,
  input wire pss_pkg::pss_rx_s i_rx,
  input wire pss_pkg::pss_tx_s i_tx,
  output pss_pkg::pss_inc_s o_inc
);
  import pss_pkg::*;

  pss_inc_s inc_next;
  logic [`PSS_LEN_W-1:0] limit;
  logic legal;
  logic good;

  // ============================================================
  // receive and transmit event decode
  always_comb begin
    limit = i_max_frame_ext ? `PSS_LEN_LIMIT_EXT : `PSS_LEN_LIMIT_STD;
    legal = (i_rx.len >= `PSS_LEN_MIN) && (i_rx.len <= limit);
    good = legal && i_rx.check_ok && !i_rx.symbol_err && !i_rx.odd_bits;
    inc_next = '0;
    inc_next.rx_octets = i_rx.len;
    inc_next.tx_octets = i_tx.len;
    if (i_rx.done) begin
      inc_next.bump[`PSS_OFF_RX_LOW_PRIO_OCTETS] = !i_rx.high_prio;
      inc_next.bump[`PSS_OFF_RX_HIGH_PRIO_OCTETS] = i_rx.high_prio;
      inc_next.bump[`PSS_OFF_RX_SHORT_FRAMES] =
        (i_rx.len < `PSS_LEN_MIN) && i_rx.check_ok;
      inc_next.bump[`PSS_OFF_RX_BROKEN_FRAGMENTS] =
        (i_rx.len < `PSS_LEN_MIN) &&
        (!i_rx.check_ok || i_rx.symbol_err || i_rx.odd_bits);
      inc_next.bump[`PSS_OFF_RX_LONG_FRAMES] =
        (i_rx.len > limit) && i_rx.check_ok;
      inc_next.bump[`PSS_OFF_RX_LONG_ERRORED_FRAMES] =
        (i_rx.len > limit) &&
        (!i_rx.check_ok || i_rx.symbol_err || i_rx.odd_bits);
      inc_next.bump[`PSS_OFF_RX_BAD_SYMBOL_FRAMES] =
        legal && i_rx.symbol_err;
      inc_next.bump[`PSS_OFF_RX_BAD_CHECK_FRAMES] =
        legal && !i_rx.check_ok && !i_rx.odd_bits;
      inc_next.bump[`PSS_OFF_RX_MISALIGNED_FRAMES] =
        legal && !i_rx.check_ok && i_rx.odd_bits;
      inc_next.bump[`PSS_OFF_RX_MAC_CONTROL_FRAMES] = i_rx.mac_ctrl;
      inc_next.bump[`PSS_OFF_RX_FLOW_STOP_FRAMES] =
        i_rx.mac_ctrl && i_rx.pause_match &&
        (i_rx.len >= `PSS_LEN_MIN) && i_rx.check_ok;
      inc_next.bump[`PSS_OFF_RX_ALL_STATIONS_FRAMES] =
        good && i_rx.bcast;
      inc_next.bump[`PSS_OFF_RX_GROUP_FRAMES] =
        good && i_rx.mcast && !i_rx.bcast && !i_rx.mac_ctrl;
      inc_next.bump[`PSS_OFF_RX_SINGLE_DEST_FRAMES] =
        good && !i_rx.mcast && !i_rx.bcast;
      inc_next.bump[`PSS_OFF_RX_LEN_MIN_BIN] =
        i_rx.len == `PSS_LEN_MIN;
      inc_next.bump[`PSS_OFF_RX_LEN_BIN_2] =
        (i_rx.len > `PSS_LEN_MIN) && (i_rx.len <= `PSS_LEN_BIN2_TOP);
      inc_next.bump[`PSS_OFF_RX_LEN_BIN_3] =
        (i_rx.len > `PSS_LEN_BIN2_TOP) &&
        (i_rx.len <= `PSS_LEN_BIN3_TOP);
      inc_next.bump[`PSS_OFF_RX_LEN_BIN_4] =
        (i_rx.len > `PSS_LEN_BIN3_TOP) &&
        (i_rx.len <= `PSS_LEN_BIN4_TOP);
      inc_next.bump[`PSS_OFF_RX_LEN_BIN_5] =
        (i_rx.len > `PSS_LEN_BIN4_TOP) &&
        (i_rx.len <= `PSS_LEN_BIN5_TOP);
      inc_next.bump[`PSS_OFF_RX_LEN_BIN_6] =
        (i_rx.len > `PSS_LEN_BIN5_TOP) && (i_rx.len <= limit);
    end
    // collision pulses arrive during transmission, not at frame end
    inc_next.bump[`PSS_OFF_TX_LATE_HIT_COUNT] = i_tx.late_hit;
    inc_next.bump[`PSS_OFF_TX_ALL_HITS] =
      i_tx.hit && i_tx.half_duplex;
    if (i_tx.done) begin
      inc_next.bump[`PSS_OFF_TX_LOW_PRIO_OCTETS] =
        i_tx.sent_ok && !i_tx.high_prio;
      inc_next.bump[`PSS_OFF_TX_HIGH_PRIO_OCTETS] =
        i_tx.sent_ok && i_tx.high_prio;
      inc_next.bump[`PSS_OFF_TX_FLOW_STOP_FRAMES] =
        i_tx.sent_ok && i_tx.pause;
      inc_next.bump[`PSS_OFF_TX_ALL_STATIONS_FRAMES] =
        i_tx.sent_ok && i_tx.bcast;
      inc_next.bump[`PSS_OFF_TX_GROUP_FRAMES] =
        i_tx.sent_ok && i_tx.mcast && !i_tx.bcast;
      inc_next.bump[`PSS_OFF_TX_SINGLE_DEST_FRAMES] =
        i_tx.sent_ok && !i_tx.mcast && !i_tx.bcast;
      inc_next.bump[`PSS_OFF_TX_POSTPONED_FRAMES] = i_tx.postponed;
      inc_next.bump[`PSS_OFF_TX_ABANDONED_FRAMES] =
        !i_tx.sent_ok && i_tx.excessive;
      inc_next.bump[`PSS_OFF_TX_ONE_HIT_FRAMES] =
        i_tx.sent_ok && (i_tx.hits == 5'h01);
      inc_next.bump[`PSS_OFF_TX_MULTI_HIT_FRAMES] =
        i_tx.sent_ok && (i_tx.hits > 5'h01);
    end
  end

  // ============================================================
  // registered increment request
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_inc <= '0;
    end else begin
      o_inc <= inc_next;
    end
  end

endmodule : pss_frame_classifier

// ### logic/pss_pkg.sv
`include "pss_cfg.svh"

package pss_pkg;

  // ============================================================
  // receive frame summary, one-cycle done pulse per frame
  typedef struct packed {
    logic done;
    logic [`PSS_LEN_W-1:0] len;
    logic check_ok;
    logic symbol_err;
    logic odd_bits;
    logic high_prio;
    logic bcast;
    logic mcast;
    logic mac_ctrl;
    logic pause_match;
  } pss_rx_s;

  // transmit frame summary and collision pulses
  typedef struct packed {
    logic done;
    logic sent_ok;
    logic [`PSS_LEN_W-1:0] len;
    logic high_prio;
    logic bcast;
    logic mcast;
    logic pause;
    logic postponed;
    logic [4:0] hits;
    logic excessive;
    logic hit;
    logic late_hit;
    logic half_duplex;
  } pss_tx_s;

  // per-port increment request toward the counter store
  typedef struct packed {
    logic [`PSS_PER_PORT-1:0] bump;
    logic [`PSS_LEN_W-1:0] rx_octets;
    logic [`PSS_LEN_W-1:0] tx_octets;
  } pss_inc_s;

endpackage : pss_pkg

// ### logic/pss_port_stat_counters.sv
`timescale 1ns/1ns
`include "pss_cfg.svh"

// Overview of operation
// - 32 counters per port, two groups
// - count in 29:0, valid flag bit 30
// - overflow flag bit 31, all reset zero
// - port bases 0x00, 0x20, 0x40 plus offset
// - offsets 0-1 receive octets by priority
// - offsets 2-3 short frames and fragments
// - offset 4 long good frames, limit selectable
// - offset 5 long frames with errors
// - offset 6 legal frames with bad symbol
// - offsets 7-8 bad check, whole or odd
// - offset 9 MAC control frames
// - offset 0xA qualified flow stop frames
// - offsets 0xB-0xD good frames by destination
// - offsets 0xE-0x13 all frames from 64 bytes to limit, by length
// - offsets 0x14-0x15 good transmit octets
// - offset 0x16 late collisions
// - offsets 0x17-0x1A transmit frame kinds
// - offset 0x1B postponed first attempts
// - offsets 0x1C-0x1D collisions and abandons
// - offsets 0x1E-0x1F one or many collisions
// - dropped word: 16-bit count, upper reserved
// - indices 0x00-0x05 transmit/receive drops
// - reading a port counter clears it
// - drop counters keep value, no flags

module pss_port_stat_counters (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_max_frame_ext,
  input wire pss_pkg::pss_rx_s i_rx [`PSS_PORTS],
  input wire pss_pkg::pss_tx_s i_tx [`PSS_PORTS],
  input wire logic [`PSS_PORTS-1:0] i_tx_drop,
  input wire logic [`PSS_PORTS-1:0] i_rx_drop,
  input wire logic i_rd_req,
  input wire logic [7:0] i_rd_table,
  input wire logic [7:0] i_rd_index,
  output logic o_rd_valid,
  output logic [31:0] o_rd_data
);
  import pss_pkg::*;

  // ============================================================
  // helpers

  // amount added to a port counter for one increment request
  function automatic logic [`PSS_CNT_W-1:0] step_amount(
    input logic [4:0] off,
    input pss_inc_s inc
  );
    logic [`PSS_CNT_W-1:0] amt;
    amt = '0;
    if (inc.bump[off]) begin
      unique case (off)
        `PSS_OFF_RX_LOW_PRIO_OCTETS,
        `PSS_OFF_RX_HIGH_PRIO_OCTETS: begin
          amt = `PSS_CNT_W'(inc.rx_octets);
        end
        `PSS_OFF_TX_LOW_PRIO_OCTETS,
        `PSS_OFF_TX_HIGH_PRIO_OCTETS: begin
          amt = `PSS_CNT_W'(inc.tx_octets);
        end
        default: begin
          amt = `PSS_CNT_W'(1);
        end
      endcase
    end
    return amt;
  endfunction : step_amount

  // true when the selected table and index name a port counter
  function automatic logic is_port_sel(
    input logic [7:0] table_sel,
    input logic [7:0] index
  );
    return (table_sel == `PSS_SEL_PORT) &&
      (index <= `PSS_PORT_LAST_INDEX);
  endfunction : is_port_sel

  // true when the selected table and index name a drop counter
  function automatic logic is_drop_sel(
    input logic [7:0] table_sel,
    input logic [7:0] index
  );
    return (table_sel == `PSS_SEL_DROP) &&
      (index <= `PSS_DROP_LAST_INDEX);
  endfunction : is_drop_sel

  // ============================================================
  // frame classification, one instance per switch port
  pss_inc_s inc [`PSS_PORTS];

  genvar gp;
  generate
    for (gp = 0; gp < `PSS_PORTS; gp++) begin : g_class
      pss_frame_classifier u_class (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_max_frame_ext(i_max_frame_ext),
        .i_rx(i_rx[gp]),
        .i_tx(i_tx[gp]),
        .o_inc(inc[gp])
      );
    end
  endgenerate

  // ============================================================
  // read decode
  logic port_hit;
  logic drop_hit;
  logic [6:0] port_entry;
  logic [2:0] drop_entry;

  // the index byte selects port and offset directly
  assign port_hit = i_rd_req && is_port_sel(i_rd_table, i_rd_index);
  assign drop_hit = i_rd_req && is_drop_sel(i_rd_table, i_rd_index);
  assign port_entry = i_rd_index[6:0];
  assign drop_entry = i_rd_index[2:0];

  // ============================================================
  // per-port counter store: 96 entries of count and overflow
  logic [`PSS_CNT_W-1:0] cnt_reg [`PSS_PORT_ENTRIES];
  logic ovf_reg [`PSS_PORT_ENTRIES];

  genvar ge;
  generate
    for (ge = 0; ge < `PSS_PORT_ENTRIES; ge++) begin : g_port_cnt
      localparam int PORT = ge / `PSS_PER_PORT;
      localparam logic [4:0] OFF = 5'(ge % `PSS_PER_PORT);
      logic [`PSS_CNT_W-1:0] amt;
      logic [`PSS_CNT_W:0] sum;
      logic clear;

      // a read clears the entry; a same-cycle event lands after clear
      assign amt = step_amount(OFF, inc[PORT]);
      assign sum = {1'b0, cnt_reg[ge]} + {1'b0, amt};
      assign clear = port_hit && (port_entry == 7'(ge));

      // count update with wrap
      always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          cnt_reg[ge] <= '0;
        end else if (clear) begin
          cnt_reg[ge] <= amt;
        end else begin
          cnt_reg[ge] <= sum[`PSS_CNT_W-1:0];
        end
      end

      // sticky overflow flag, dropped only by a read
      always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          ovf_reg[ge] <= 1'b0;
        end else if (clear) begin
          ovf_reg[ge] <= 1'b0;
        end else if (sum[`PSS_CNT_W]) begin
          ovf_reg[ge] <= 1'b1;
        end
      end
    end
  endgenerate

  // ============================================================
  // dropped-packet counters: transmit ports first, then receive
  logic [`PSS_DROP_W-1:0] drop_reg [`PSS_DROP_ENTRIES];
  logic [`PSS_DROP_ENTRIES-1:0] drop_event;

  assign drop_event = {i_rx_drop, i_tx_drop};

  genvar gd;
  generate
    for (gd = 0; gd < `PSS_DROP_ENTRIES; gd++) begin : g_drop_cnt
      // never cleared by a read, wraps without a flag
      always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          drop_reg[gd] <= '0;
        end else if (drop_event[gd]) begin
          drop_reg[gd] <= drop_reg[gd] + `PSS_DROP_W'(1);
        end
      end
    end
  endgenerate

  // ============================================================
  // read answer, one cycle after the request
  logic [31:0] rd_word;

  // word assembly; unmapped selections read as zero
  always_comb begin
    rd_word = '0;
    if (port_hit) begin
      rd_word[`PSS_CNT_W-1:0] = cnt_reg[port_entry];
      rd_word[`PSS_VALID_BIT] = 1'b1;
      rd_word[`PSS_OVF_BIT] = ovf_reg[port_entry];
    end else if (drop_hit) begin
      rd_word[`PSS_DROP_W-1:0] = drop_reg[drop_entry];
    end
  end

  // answer strobe and data register
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= i_rd_req;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rd_data <= '0;
    end else if (i_rd_req) begin
      o_rd_data <= rd_word;
    end
  end

endmodule : pss_port_stat_counters

// ### testbench/pss_host_model.sv
`timescale 1ns/1ns

// ============================================================
// host processor issuing indirect counter reads
module pss_host_model (
  input wire logic i_clk,
  input wire logic i_valid,
  input wire logic [31:0] i_data,
  output logic o_req,
  output logic [7:0] o_table,
  output logic [7:0] o_index
);
  // idle values before the first read
  initial begin
    o_req = 1'b0;
    o_table = 8'h00;
    o_index = 8'h00;
  end

  // select table, trigger with index, reread port-table words flagged not valid
  task automatic read(input logic [7:0] tbl, input logic [7:0] idx,
                      input int reps, output logic [31:0] d);
    int tries;
    int w;
    tries = 0;
    do begin
      @(negedge i_clk);
      o_table <= tbl;
      o_index <= idx;
      o_req <= 1'b1;
      repeat (reps) @(negedge i_clk);
      o_req <= 1'b0;
      o_table <= ~tbl; // released lines never keep the old value
      o_index <= ~idx;
      w = 0;
      while (i_valid !== 1'b1 && w < 4) begin
        @(negedge i_clk);
        w++;
      end
      // no answer strobe in time: hand back unknown so the compare trips
      d = (i_valid === 1'b1) ? i_data : 32'hxxxx_xxxx;
      tries++;
    end while (tbl == 8'h1c && d[30] !== 1'b1 && tries < 3);
  endtask : read
endmodule : pss_host_model

// ### testbench/pss_stat_assertions.sv
`timescale 1ns/1ns
`include "pss_cfg.svh"

// ============================================================
// read port checks on the statistics counters
module pss_stat_assertions (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [`PSS_PORTS-1:0] i_tx_drop,
  input wire logic [`PSS_PORTS-1:0] i_rx_drop,
  input wire logic i_rd_req,
  input wire logic [7:0] i_rd_table,
  input wire logic [7:0] i_rd_index,
  input wire logic o_rd_valid,
  input wire logic [31:0] o_rd_data
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);

  // request kinds decoded from table and index
  wire port_rd = i_rd_req && i_rd_table == `PSS_SEL_PORT &&
                 i_rd_index <= `PSS_PORT_LAST_INDEX;
  wire drop_rd = i_rd_req && i_rd_table == `PSS_SEL_DROP &&
                 i_rd_index <= `PSS_DROP_LAST_INDEX;
  wire unmap_rd = i_rd_req && !port_rd && !drop_rd;

  property p_valid_lat;
    i_rd_req |=> o_rd_valid;
  endproperty
  a_valid_lat: assert property (p_valid_lat)
    else $error("read answer missing one cycle after request");

  property p_valid_pulse;
    !i_rd_req |=> !o_rd_valid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse)
    else $error("answer strobe without request");

  property p_port_flag;
    port_rd |=> o_rd_valid && o_rd_data[`PSS_VALID_BIT];
  endproperty
  a_port_flag: assert property (p_port_flag)
    else $error("port word without valid flag");

  property p_drop_resv;
    drop_rd |=> o_rd_data[30:16] == 15'h0;
  endproperty
  a_drop_resv: assert property (p_drop_resv)
    else $error("drop word upper bits not zero");

  property p_drop_flags;
    drop_rd |=> !o_rd_data[`PSS_OVF_BIT];
  endproperty
  a_drop_flags: assert property (p_drop_flags)
    else $error("drop word shows overflow");

  property p_drop_keep;
    drop_rd && i_tx_drop == 3'h0 && i_rx_drop == 3'h0 ##1
      i_rd_req && $stable(i_rd_index) && $stable(i_rd_table)
      |=> $stable(o_rd_data);
  endproperty
  a_drop_keep: assert property (p_drop_keep)
    else $error("drop counter changed by a read");

  property p_unmapped;
    unmap_rd |=> o_rd_data == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped index returned data");

  property p_hold;
    !i_rd_req |=> $stable(o_rd_data);
  endproperty
  a_hold: assert property (p_hold)
    else $error("answer word changed without request");

  property p_reset_zero;
    $rose(i_reset_n) |-> o_rd_data == 32'h0 && !o_rd_valid;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("read port not cleared by reset");

  // main scenarios reached
  c_port_read: cover property (port_rd ##1 o_rd_valid);
  c_drop_read: cover property (drop_rd ##1 o_rd_valid);
  c_unmap_read: cover property (unmap_rd ##1 o_rd_valid);
endmodule : pss_stat_assertions

bind pss_port_stat_counters pss_stat_assertions i_pss_stat_assertions (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_tx_drop(i_tx_drop),
  .i_rx_drop(i_rx_drop), .i_rd_req(i_rd_req), .i_rd_table(i_rd_table),
  .i_rd_index(i_rd_index), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data)
);

// ### testbench/tb_top.sv
`timescale 1ns/1ns
`include "pss_cfg.svh"

// ============================================================
// bench for the per-port and dropped-frame counters
module tb_top;
  import pss_pkg::*;
  logic clk;
  logic reset_n;
  logic max_ext;
  pss_rx_s rx_in [`PSS_PORTS];
  pss_tx_s tx_in [`PSS_PORTS];
  logic [2:0] tx_drop;
  logic [2:0] rx_drop;
  logic rd_req;
  logic [7:0] rd_table;
  logic [7:0] rd_index;
  logic rd_valid;
  logic [31:0] rd_data;
  int bad_count;
  int checks;
  logic [10:0] f_len [12] = '{11'd64, 11'd100, 11'd200, 11'd300, 11'd40,
    11'd40, 11'd600, 11'd700, 11'd800, 11'd1530, 11'd1600, 11'd1530};
  logic [7:0] f_flag [12] = '{8'h80, 8'h98, 8'h84, 8'h87, 8'h80, 8'h00,
    8'h00, 8'h20, 8'hc0, 8'h80, 8'h00, 8'h80};
  logic [29:0] rx_exp [20] = '{30'd7404, 30'd100, 30'd1, 30'd1, 30'd1,
    30'd1, 30'd1, 30'd1, 30'd1, 30'd1, 30'd1, 30'd1, 30'd1, 30'd2, 30'd1,
    30'd1, 30'd1, 30'd1, 30'd3, 30'd1};
  pss_tx_s t_vec [8] = '{{2'b11, 11'd500, 5'b01000, 5'd0, 4'b0000},
    {2'b11, 11'd300, 5'b10101, 5'd1, 4'b0000},
    {2'b11, 11'd100, 5'b00000, 5'd3, 4'b0000},
    {2'b10, 11'd200, 5'b00000, 5'd16, 4'b1000},
    27'd5, 27'd5, 27'd4, 27'd2};
  logic [29:0] tx_exp [12] = '{30'd600, 30'd300, 30'd1, 30'd0, 30'd1,
    30'd1, 30'd1, 30'd1, 30'd2, 30'd1, 30'd1, 30'd1};

  pss_port_stat_counters i_pss_port_stat_counters (
    .i_clk(clk), .i_reset_n(reset_n), .i_max_frame_ext(max_ext),
    .i_rx(rx_in), .i_tx(tx_in), .i_tx_drop(tx_drop), .i_rx_drop(rx_drop),
    .i_rd_req(rd_req), .i_rd_table(rd_table), .i_rd_index(rd_index),
    .o_rd_valid(rd_valid), .o_rd_data(rd_data)
  );

  pss_host_model i_pss_host_model (
    .i_clk(clk), .i_valid(rd_valid), .i_data(rd_data),
    .o_req(rd_req), .o_table(rd_table), .o_index(rd_index)
  );

  // free running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // verdict and end of run
  task automatic stop_test;
    if (bad_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  // read one word and compare it
  task automatic rd(input logic [7:0] tbl, input logic [7:0] idx,
                    input int reps, input logic [31:0] exp);
    logic [31:0] got;
    i_pss_host_model.read(tbl, idx, reps, got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED table %h index %h expected %h seen %h",
               tbl, idx, exp, got);
    end
  endtask : rd

  // one-cycle frame summaries on a port
  task automatic ev(input int p, input pss_rx_s r, input pss_tx_s t);
    @(negedge clk);
    rx_in[p] = r;
    tx_in[p] = t;
    @(negedge clk);
    rx_in[p] = '0;
    tx_in[p] = '0;
  endtask : ev

  // hang guard
  initial begin
    repeat (80000) @(posedge clk);
    bad_count++;
    stop_test();
  end

  // main sequence
  initial begin
    bad_count = 0;
    checks = 0;
    reset_n = 1'b0;
    max_ext = 1'b0;
    rx_in = '{default: '0};
    tx_in = '{default: '0};
    tx_drop = 3'b000;
    rx_drop = 3'b000;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    rd(8'h1c, 8'h0e, 1, 32'h4000_0000);
    // receive frame mix on port 2, size limit switched before the last
    foreach (f_len[k]) begin
      if (k == 11) begin
        repeat (3) @(negedge clk);
        max_ext = 1'b1;
      end
      ev(1, {1'b1, f_len[k], f_flag[k]}, '0);
    end
    repeat (2) @(negedge clk);
    foreach (rx_exp[k]) begin
      rd(8'h1c, 8'h20 + 8'(k), 1, {2'b01, rx_exp[k]});
    end
    foreach (rx_exp[k]) begin
      rd(8'h1c, 8'h20 + 8'(k), 1, 32'h4000_0000);
    end
    rd(8'h1c, 8'h0d, 1, 32'h4000_0000);
    // back-to-back reads: the second sees the cleared counter
    ev(2, {1'b1, 11'd64, 8'h80}, '0);
    repeat (2) @(negedge clk);
    rd(8'h1c, 8'h4e, 2, 32'h4000_0000);
    // transmit results and collision pulses on port 3, one pause frame on port 1
    foreach (t_vec[k]) ev(2, '0, t_vec[k]);
    ev(0, '0, {2'b11, 11'd64, 5'b00010, 5'd0, 4'b0000});
    repeat (2) @(negedge clk);
    foreach (tx_exp[k]) begin
      rd(8'h1c, 8'h54 + 8'(k), 1, {2'b01, tx_exp[k]});
    end
    rd(8'h1c, 8'h17, 1, 32'h4000_0001);
    rd(8'h1c, 8'h14, 1, 32'h4000_0040);
    // dropped frames, back-to-back pulses
    @(negedge clk);
    tx_drop = 3'b010;
    rx_drop = 3'b100;
    @(negedge clk);
    rx_drop = 3'b000;
    repeat (2) @(negedge clk);
    tx_drop = 3'b000;
    rd(8'h1d, 8'h01, 2, 32'h0000_0003);
    rd(8'h1d, 8'h05, 1, 32'h0000_0001);
    rd(8'h1d, 8'h03, 1, 32'h0000_0000);
    rd(8'h1c, 8'h60, 1, 32'h0000_0000);
    rd(8'h1d, 8'h06, 1, 32'h0000_0000);
    rd(8'h10, 8'h00, 1, 32'h0000_0000);
    // one more drop than the 16-bit range holds
    @(negedge clk);
    tx_drop = 3'b001;
    repeat (65537) @(negedge clk);
    tx_drop = 3'b000;
    rd(8'h1d, 8'h00, 1, 32'h0000_0001);
    stop_test();
  end
endmodule : tb_top
